// File: hw/clt_ctrl.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module clt_ctrl
  import clt_pkg::*;
#(
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_0  = CLT_SLEEP_CYC_0,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_1  = CLT_SLEEP_CYC_1,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_2  = CLT_SLEEP_CYC_2,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_3  = CLT_SLEEP_CYC_3,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_4  = CLT_SLEEP_CYC_4,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_5  = CLT_SLEEP_CYC_5,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_6  = CLT_SLEEP_CYC_6,
  parameter logic [CLT_CNT_W-1:0] SLEEP_CYC_7  = CLT_SLEEP_CYC_7,
  parameter logic [CLT_CNT_W-1:0] SETTLE_CYC_0 = CLT_SETTLE_CYC_0,
  parameter logic [CLT_CNT_W-1:0] SETTLE_CYC_1 = CLT_SETTLE_CYC_1,
  parameter logic [CLT_CNT_W-1:0] SETTLE_CYC_2 = CLT_SETTLE_CYC_2,
  parameter logic [CLT_CNT_W-1:0] SETTLE_CYC_3 = CLT_SETTLE_CYC_3
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [CLT_ADDR_W-1:0] addr,
  input  wire logic [CLT_DATA_W-1:0] wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [CLT_DATA_W-1:0] rd_data,
  input  wire logic                  calibration_trigger_pin,
  input  wire logic                  foreground_done_flag,
  input  wire logic                  calibration_halted_flag,
  input  wire logic                  alarm,
  input  wire logic                  background_recal_enable,
  input  wire logic                  offline_cal_done,
  output logic                       calibration_status_pin,
  output logic                       calibration_trigger,
  output logic                       offline_core_sleep,
  output logic                       offline_core_settle,
  output logic                       offline_core_calibrate,
  output logic                       irq
);

  if (SLEEP_CYC_0 == '0 || SLEEP_CYC_1 == '0 || SLEEP_CYC_2 == '0 || SLEEP_CYC_3 == '0 ||
      SLEEP_CYC_4 == '0 || SLEEP_CYC_5 == '0 || SLEEP_CYC_6 == '0 || SLEEP_CYC_7 == '0 ||
      SETTLE_CYC_0 == '0 || SETTLE_CYC_1 == '0 || SETTLE_CYC_2 == '0 || SETTLE_CYC_3 == '0)
  begin : g_bad_interval
    $error("Every interval must be at least one cycle.");
  end

  // Register storage.
  logic [7:0]          calib_pin_config;
  logic [7:0]          calib_software_trigger;
  logic [7:0]          lowpower_calib_control;
  logic [CLT_EV_N-1:0] irq_status;
  logic [CLT_EV_N-1:0] irq_mask;

  // Field views.
  wire                 trigger_source_pin_select = calib_pin_config[CLT_PIN_SEL_BIT];
  wire  [1:0]          status_select             = calib_pin_config[CLT_STAT_SEL_LSB +: 2];
  wire                 software_trigger_bit      = calib_software_trigger[CLT_SOFT_TRIG_BIT];
  wire                 low_power_recal_enable    = lowpower_calib_control[CLT_LOW_POWER_RECAL_ENABLE_BIT];
  wire                 trigger_controlled_sleep  = lowpower_calib_control[CLT_TRIGGER_CONTROLLED_SLEEP_BIT];
  wire  [1:0]          settle_interval_code      = lowpower_calib_control[CLT_SETTLE_LSB +: 2];
  wire  [2:0]          sleep_interval_code       = lowpower_calib_control[CLT_SLEEP_LSB +: 3];

  // Write decode.
  wire                 wr_pin_cfg    = wr_en && (addr == CLT_ADDR_PIN_CFG);
  wire                 wr_soft_trig  = wr_en && (addr == CLT_ADDR_SOFT_TRIG);
  wire                 wr_lp_ctrl    = wr_en && (addr == CLT_ADDR_LP_CTRL);
  wire                 wr_irq_status = wr_en && (addr == CLT_ADDR_IRQ_STATUS);
  wire                 wr_irq_mask   = wr_en && (addr == CLT_ADDR_IRQ_MASK);

  // Trigger selection.
  logic                trigger_pin_sync;
  wire                 selected_trigger;

  clt_sync u_trig_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (calibration_trigger_pin),
    .sync_out (trigger_pin_sync)
  );

  // The raw pin never reaches this mux, only its synchronised copy.
  assign selected_trigger = trigger_source_pin_select ? trigger_pin_sync
                                                      : software_trigger_bit;

  // Status pin source.
  logic                next_status_pin;

  always_comb begin
    case (status_select)
      CLT_STAT_FOREGROUND_DONE_FLAG: next_status_pin = foreground_done_flag;
      CLT_STAT_HALTED:  next_status_pin = calibration_halted_flag;
      CLT_STAT_ALARM:   next_status_pin = alarm;
      default:          next_status_pin = 1'b0;
    endcase
  end

  // Interval lookup.
  function automatic logic [CLT_CNT_W-1:0] sleep_cycles(input logic [2:0] code);
    logic [CLT_CNT_W-1:0] r;
    case (code)
      3'h0:    r = SLEEP_CYC_0;
      3'h1:    r = SLEEP_CYC_1;
      3'h2:    r = SLEEP_CYC_2;
      3'h3:    r = SLEEP_CYC_3;
      3'h4:    r = SLEEP_CYC_4;
      3'h5:    r = SLEEP_CYC_5;
      3'h6:    r = SLEEP_CYC_6;
      default: r = SLEEP_CYC_7;
    endcase
    return r;
  endfunction

  function automatic logic [CLT_CNT_W-1:0] settle_cycles(input logic [1:0] code);
    logic [CLT_CNT_W-1:0] r;
    case (code)
      2'h0:    r = SETTLE_CYC_0;
      2'h1:    r = SETTLE_CYC_1;
      2'h2:    r = SETTLE_CYC_2;
      default: r = SETTLE_CYC_3;
    endcase
    return r;
  endfunction

  // Low-power sequencing of the offline core.
  clt_lp_state_t        state;
  clt_lp_state_t        next_state;
  logic                 timer_expired;
  logic [CLT_CNT_W-1:0] timer_remaining;

  // Without background calibration the enable bit is ignored.
  wire                  lp_active   = low_power_recal_enable && background_recal_enable;
  wire                  sleep_done  = trigger_controlled_sleep ? !calibration_trigger
                                                               : timer_expired;
  wire                  enter_sleep  = (next_state == CLT_ST_SLEEP) && (state != CLT_ST_SLEEP);
  wire                  enter_settle = (next_state == CLT_ST_SETTLE) && (state != CLT_ST_SETTLE);
  wire                  timer_load   = enter_sleep || enter_settle;
  wire [CLT_CNT_W-1:0]  timer_value  = enter_sleep ? sleep_cycles(sleep_interval_code)
                                                   : settle_cycles(settle_interval_code);

  always_comb begin
    next_state = state;
    case (state)
      CLT_ST_IDLE: begin
        if (lp_active) begin
          next_state = CLT_ST_SLEEP;
        end
      end
      CLT_ST_SLEEP: begin
        if (!lp_active) begin
          next_state = CLT_ST_IDLE;
        end else if (sleep_done) begin
          next_state = CLT_ST_SETTLE;
        end
      end
      CLT_ST_SETTLE: begin
        if (!lp_active) begin
          next_state = CLT_ST_IDLE;
        end else if (timer_expired) begin
          next_state = CLT_ST_CAL;
        end
      end
      default: begin
        if (!lp_active) begin
          next_state = CLT_ST_IDLE;
        end else if (offline_cal_done) begin
          next_state = CLT_ST_SLEEP;
        end
      end
    endcase
  end

  clt_interval_timer #(
    .CNT_W (CLT_CNT_W)
  ) u_timer (
    .clk        (clk),
    .srst       (srst),
    .load       (timer_load),
    .load_value (timer_value),
    .remaining  (timer_remaining),
    .expired    (timer_expired)
  );

  // Event sources; the set term wins over a write-one-to-clear in the same cycle.
  logic                foreground_done_flag_q;
  logic                halted_q;
  logic                alarm_q;
  wire  [CLT_EV_N-1:0] irq_events;
  wire  [CLT_EV_N-1:0] irq_clear = wr_irq_status ? wr_data[CLT_EV_N-1:0] : '0;

  assign irq_events[CLT_EV_FOREGROUND_DONE_FLAG]  = foreground_done_flag && !foreground_done_flag_q;
  assign irq_events[CLT_EV_HALTED]   = calibration_halted_flag && !halted_q;
  assign irq_events[CLT_EV_ALARM]    = alarm && !alarm_q;
  assign irq_events[CLT_EV_WAKE]     = enter_settle;
  assign irq_events[CLT_EV_CAL_DONE] = (state == CLT_ST_CAL) && offline_cal_done;

  // Read mux.
  logic [7:0]          next_rd_data;

  always_comb begin
    if (!rd_en) begin
      next_rd_data = 8'h00;
    end else if (addr == CLT_ADDR_PIN_CFG) begin
      next_rd_data = calib_pin_config;
    end else if (addr == CLT_ADDR_SOFT_TRIG) begin
      next_rd_data = calib_software_trigger;
    end else if (addr == CLT_ADDR_LP_CTRL) begin
      next_rd_data = lowpower_calib_control;
    end else if (addr == CLT_ADDR_IRQ_STATUS) begin
      next_rd_data = 8'(irq_status);
    end else if (addr == CLT_ADDR_IRQ_MASK) begin
      next_rd_data = 8'(irq_mask);
    end else if (addr == CLT_ADDR_LP_STATE) begin
      next_rd_data = {4'h0, trigger_pin_sync, calibration_trigger, state};
    end else begin
      next_rd_data = 8'h00;
    end
  end

  // The three control registers are stored whole and irq_mask keeps only its low CLT_EV_N bits; keeping reserved bits at reset value is software's duty.
  always_ff @(posedge clk) begin
    if (srst) begin
      calib_pin_config       <= CLT_RST_PIN_CFG;
      calib_software_trigger <= CLT_RST_SOFT_TRIG;
      lowpower_calib_control <= CLT_RST_LP_CTRL;
      irq_mask               <= CLT_EV_N'(CLT_RST_IRQ_MASK);
    end else begin
      if (wr_pin_cfg) begin
        calib_pin_config <= wr_data;
      end
      if (wr_soft_trig) begin
        calib_software_trigger <= wr_data;
      end
      if (wr_lp_ctrl) begin
        lowpower_calib_control <= wr_data;
      end
      if (wr_irq_mask) begin
        irq_mask <= wr_data[CLT_EV_N-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status <= CLT_EV_N'(CLT_RST_IRQ_STATUS);
      foreground_done_flag_q  <= 1'b0;
      halted_q   <= 1'b0;
      alarm_q    <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      foreground_done_flag_q  <= foreground_done_flag;
      halted_q   <= calibration_halted_flag;
      alarm_q    <= alarm;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state                  <= CLT_ST_IDLE;
      rd_data                <= 8'h00;
      calibration_status_pin <= 1'b0;
      calibration_trigger    <= 1'b1;
      offline_core_sleep     <= 1'b0;
      offline_core_settle    <= 1'b0;
      offline_core_calibrate <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      state                  <= next_state;
      rd_data                <= next_rd_data;
      calibration_status_pin <= next_status_pin;
      calibration_trigger    <= selected_trigger;
      offline_core_sleep     <= (next_state == CLT_ST_SLEEP);
      offline_core_settle    <= (next_state == CLT_ST_SETTLE);
      offline_core_calibrate <= (next_state == CLT_ST_CAL);
      irq                    <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
    end
  end

  // Checks.
  status_low_a: assert property (@(posedge clk) disable iff (srst)
    (status_select == CLT_STAT_LOW) |=> !calibration_status_pin)
    else $error("Status pin not low with select value three.");

  status_fg_a: assert property (@(posedge clk) disable iff (srst)
    (status_select == CLT_STAT_FOREGROUND_DONE_FLAG) |=> calibration_status_pin == $past(foreground_done_flag))
    else $error("Status pin does not follow the foreground-done flag.");

  soft_trig_a: assert property (@(posedge clk) disable iff (srst)
    (!trigger_source_pin_select && !$changed(software_trigger_bit)) ##1 1'b1
      |-> calibration_trigger == $past(software_trigger_bit))
    else $error("Trigger does not follow the software bit.");

  hw_trig_a: assert property (@(posedge clk) disable iff (srst)
    trigger_source_pin_select |=> calibration_trigger == $past(trigger_pin_sync))
    else $error("Trigger does not follow the synchronised pin.");

  sleep_load_a: assert property (@(posedge clk) disable iff (srst)
    enter_sleep |=> timer_remaining == $past(sleep_cycles(sleep_interval_code)) - CLT_CNT_W'(1))
    else $error("Sleep interval loaded with the wrong length.");

  settle_load_a: assert property (@(posedge clk) disable iff (srst)
    enter_settle |=> timer_remaining == $past(settle_cycles(settle_interval_code)) - CLT_CNT_W'(1))
    else $error("Settle interval loaded with the wrong length.");

  lp_gate_a: assert property (@(posedge clk) disable iff (srst)
    !lp_active |=> state == CLT_ST_IDLE && !offline_core_sleep)
    else $error("Low-power sequence ran without both enables.");

  sequence s_trig_asleep;
    state == CLT_ST_SLEEP && lp_active && trigger_controlled_sleep;
  endsequence

  sequence s_woken;
    state == CLT_ST_SETTLE ##1 1'b1;
  endsequence

  trig_wake_a: assert property (@(posedge clk) disable iff (srst)
    (s_trig_asleep ##0 !calibration_trigger) |=> s_woken)
    else $error("Core did not wake on a low trigger.");

  trig_hold_a: assert property (@(posedge clk) disable iff (srst)
    (s_trig_asleep ##0 calibration_trigger) |=> state == CLT_ST_SLEEP)
    else $error("Core woke while the trigger was high.");

  auto_sleep_a: assert property (@(posedge clk) disable iff (srst)
    (state == CLT_ST_SLEEP && lp_active && !trigger_controlled_sleep && !timer_expired)
      |=> state == CLT_ST_SLEEP)
    else $error("Core woke before the sleep interval ended.");

  reset_val_a: assert property (@(posedge clk)
    srst |=> lowpower_calib_control == CLT_RST_LP_CTRL && calib_software_trigger == CLT_RST_SOFT_TRIG)
    else $error("Control registers not at reset value.");

  irq_set_wins_a: assert property (@(posedge clk) disable iff (srst)
    (irq_events[CLT_EV_WAKE] && irq_clear[CLT_EV_WAKE]) |=> irq_status[CLT_EV_WAKE])
    else $error("Wake event lost against a clear.");

endmodule

// File: hw/clt_interval_timer.sv
`timescale 1ns/1ps
module clt_interval_timer
  import clt_pkg::*;
#(
  parameter int CNT_W = CLT_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_value,
  output logic      [CNT_W-1:0] remaining,
  output logic                  expired
);

  if (CNT_W < 2) begin : g_bad_width
    $error("Interval counter needs at least two bits.");
  end

  // A load of N makes expired rise N cycles later, so the caller's state lasts N cycles.
  always_ff @(posedge clk) begin
    if (srst) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= load_value - CNT_W'(1);
    end else if (remaining != '0) begin
      remaining <= remaining - CNT_W'(1);
    end
  end

  assign expired = (remaining == '0);

  timer_count_a: assert property (@(posedge clk) disable iff (srst)
    (!load && remaining != '0) |=> remaining == $past(remaining) - CNT_W'(1))
    else $error("Interval counter did not step down by one.");

endmodule

// File: hw/clt_pkg.sv
package clt_pkg;

  // Register bus geometry.
  localparam int          CLT_ADDR_W = 8;
  localparam int          CLT_DATA_W = 8;

  // Register offsets.
  localparam logic [7:0]  CLT_ADDR_PIN_CFG    = 8'h6b;
  localparam logic [7:0]  CLT_ADDR_SOFT_TRIG  = 8'h6c;
  localparam logic [7:0]  CLT_ADDR_LP_CTRL    = 8'h6e;
  localparam logic [7:0]  CLT_ADDR_IRQ_STATUS = 8'h70;
  localparam logic [7:0]  CLT_ADDR_IRQ_MASK   = 8'h71;
  localparam logic [7:0]  CLT_ADDR_LP_STATE   = 8'h72;

  // Reset values.
  localparam logic [7:0]  CLT_RST_PIN_CFG    = 8'h00;
  localparam logic [7:0]  CLT_RST_SOFT_TRIG  = 8'h01;
  localparam logic [7:0]  CLT_RST_LP_CTRL    = 8'h88;
  localparam logic [7:0]  CLT_RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0]  CLT_RST_IRQ_MASK   = 8'h00;

  // Field positions.
  localparam int          CLT_PIN_SEL_BIT    = 0;
  localparam int          CLT_STAT_SEL_LSB   = 1;
  localparam int          CLT_SOFT_TRIG_BIT  = 0;
  localparam int          CLT_LOW_POWER_RECAL_ENABLE_BIT      = 0;
  localparam int          CLT_TRIGGER_CONTROLLED_SLEEP_BIT    = 1;
  localparam int          CLT_SETTLE_LSB     = 3;
  localparam int          CLT_SLEEP_LSB      = 5;

  // Interrupt status bit positions.
  localparam int          CLT_EV_FOREGROUND_DONE_FLAG     = 0;
  localparam int          CLT_EV_HALTED      = 1;
  localparam int          CLT_EV_ALARM       = 2;
  localparam int          CLT_EV_WAKE        = 3;
  localparam int          CLT_EV_CAL_DONE    = 4;
  localparam int          CLT_EV_N           = 5;

  // Interval counter width; the longest interval needs 41 bits.
  localparam int          CLT_CNT_W          = 41;

  // Intervals in sample clock periods, and the clock cycles per period.
  localparam logic [40:0] CLT_CYC_PER_PERIOD = 41'h1;
  localparam logic [40:0] CLT_SLEEP_PER_0    = 41'd1152;
  localparam logic [40:0] CLT_SLEEP_PER_1    = 41'd4194432;
  localparam logic [40:0] CLT_SLEEP_PER_2    = 41'd33554560;
  localparam logic [40:0] CLT_SLEEP_PER_3    = 41'd268435584;
  localparam logic [40:0] CLT_SLEEP_PER_4    = 41'd2147483776;
  localparam logic [40:0] CLT_SLEEP_PER_5    = 41'd17179869312;
  localparam logic [40:0] CLT_SLEEP_PER_6    = 41'd137438953600;
  localparam logic [40:0] CLT_SLEEP_PER_7    = 41'd1099511627904;
  localparam logic [40:0] CLT_SETTLE_PER_0   = 41'd1152;
  localparam logic [40:0] CLT_SETTLE_PER_1   = 41'd33554560;
  localparam logic [40:0] CLT_SETTLE_PER_2   = 41'd268435584;
  localparam logic [40:0] CLT_SETTLE_PER_3   = 41'd2147483776;

  // The block runs on the sample clock itself, so the factor is one.
  localparam logic [40:0] CLT_SLEEP_CYC_0    = 41'(CLT_SLEEP_PER_0 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_1    = 41'(CLT_SLEEP_PER_1 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_2    = 41'(CLT_SLEEP_PER_2 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_3    = 41'(CLT_SLEEP_PER_3 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_4    = 41'(CLT_SLEEP_PER_4 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_5    = 41'(CLT_SLEEP_PER_5 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_6    = 41'(CLT_SLEEP_PER_6 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SLEEP_CYC_7    = 41'(CLT_SLEEP_PER_7 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SETTLE_CYC_0   = 41'(CLT_SETTLE_PER_0 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SETTLE_CYC_1   = 41'(CLT_SETTLE_PER_1 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SETTLE_CYC_2   = 41'(CLT_SETTLE_PER_2 * CLT_CYC_PER_PERIOD);
  localparam logic [40:0] CLT_SETTLE_CYC_3   = 41'(CLT_SETTLE_PER_3 * CLT_CYC_PER_PERIOD);

  // Status pin source selection.
  localparam logic [1:0]  CLT_STAT_FOREGROUND_DONE_FLAG   = 2'h0;
  localparam logic [1:0]  CLT_STAT_HALTED    = 2'h1;
  localparam logic [1:0]  CLT_STAT_ALARM     = 2'h2;
  localparam logic [1:0]  CLT_STAT_LOW       = 2'h3;

  // Offline core low-power sequence.
  typedef enum logic [1:0] {
    CLT_ST_IDLE   = 2'b00,
    CLT_ST_SLEEP  = 2'b01,
    CLT_ST_SETTLE = 2'b10,
    CLT_ST_CAL    = 2'b11
  } clt_lp_state_t;

endpackage

// File: hw/clt_sync.sv
`timescale 1ns/1ps
module clt_sync
  import clt_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

  sync_delay_a: assert property (@(posedge clk) disable iff (srst)
    (!$past(srst) && !$past(srst, 2)) |-> sync_out == $past(async_in, 2))
    else $error("Synchroniser output is not the input two cycles earlier.");

endmodule

// File: tb/clt_ctrl_tb.sv
`timescale 1ns/1ps
module clt_ctrl_tb
  import clt_pkg::*;
;
  logic       clk, srst, wr_en, rd_en, want, fg, halted, alarm, bg, rd_v, v, old;
  logic       status_pin, trig, sleep, settle, calib, irq, pin, cal_done;
  logic [7:0] addr, wr_data, rd_data;
  logic [7:0] exp_q[$];
  wire  [2:0] lp = {calib, settle, sleep};
  logic [2:0] f, rise;
  int         num_errors, n_checks, n;

  clt_ctrl #(.SLEEP_CYC_4(41'd8), .SETTLE_CYC_1(41'd4)) clt_ctrl_i (
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .calibration_trigger_pin(pin), .foreground_done_flag(fg),
    .calibration_halted_flag(halted), .alarm(alarm), .background_recal_enable(bg),
    .offline_cal_done(cal_done), .calibration_status_pin(status_pin), .calibration_trigger(trig),
    .offline_core_sleep(sleep), .offline_core_settle(settle), .offline_core_calibrate(calib), .irq(irq));
  clt_far_side clt_far_side_i (.clk(clk), .want(want), .calibrate(calib), .pin(pin), .cal_done(cal_done));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_lp(input int b, input logic val);
    n = 0;
    while (lp[b] !== val && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (lp[b] !== val) begin
      num_errors++;
      $display("unexpected timeout on sequence output %0d", b);
      conclude();
    end
  endtask
  // Counting stops at 40 so a stuck state shows up as a wrong count, not a hang.
  task automatic count_lp(input int b, input int e, input string what);
    n = 0;
    while (lp[b] === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(what, 8'(e), 8'(n));
  endtask

  // Read data stand only in the cycle after the strobe, so the monitor samples exactly there.
  always @(posedge clk) begin
    rd_v <= rd_en;
    if (rd_v === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data);
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    {wr_en, rd_en, want, fg, halted, alarm, bg} = 7'h0;
    {addr, wr_data} = 16'h0;
    void'($urandom(32'h50d4bb9a));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(CLT_ADDR_PIN_CFG, 8'h00);
    rd(CLT_ADDR_SOFT_TRIG, 8'h01);
    rd(CLT_ADDR_LP_CTRL, 8'h88);
    rd(CLT_ADDR_IRQ_MASK, 8'h00);
    rd(CLT_ADDR_IRQ_STATUS, 8'h00);
    rd(CLT_ADDR_LP_STATE, 8'h04);
    rd(8'h6d, 8'h00);
    ticks(3);
    chk("trigger", 8'h01, trig);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(CLT_ADDR_PIN_CFG, 8'(s << 1));
      repeat (4) begin
        f = 3'($urandom);
        rise = f & ~{fg, halted, alarm};
        // The clear lands in the very cycle of the flag edges, so a rising flag must survive it.
        @(posedge clk);
        {fg, halted, alarm} <= f;
        addr <= CLT_ADDR_IRQ_STATUS;
        wr_data <= 8'hff;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        ticks(2);
        chk("status_pin", s == 0 ? fg : s == 1 ? halted : s == 2 ? alarm : 1'b0, status_pin);
        rd(CLT_ADDR_IRQ_STATUS, {5'h0, rise[0], rise[1], rise[2]});
      end
    end
    $display("test status select done");
    wr(CLT_ADDR_PIN_CFG, 8'h00);
    repeat (4) begin
      v = 1'($urandom);
      wr(CLT_ADDR_SOFT_TRIG, {7'h0, v});
      want <= ~v;
      ticks(6);
      chk("soft trigger", v, trig);
    end
    wr(CLT_ADDR_PIN_CFG, 8'h01);
    repeat (4) begin
      v = 1'($urandom);
      wr(CLT_ADDR_SOFT_TRIG, {7'h0, ~v});
      ticks(6);
      old = want;
      @(posedge clk);
      want <= v;
      ticks(4);
      chk("early trigger", old, trig);
      ticks(3);
      chk("pin trigger", v, trig);
    end
    $display("test trigger source done");
    wr(CLT_ADDR_PIN_CFG, 8'h00);
    wr(CLT_ADDR_SOFT_TRIG, 8'h01);
    wr(CLT_ADDR_IRQ_STATUS, 8'hff);
    wr(CLT_ADDR_LP_CTRL, 8'h89);
    ticks(20);
    chk("sleep without bg", 8'h00, sleep);
    @(posedge clk);
    bg <= 1'b1;
    wait_lp(0, 1'b1);
    count_lp(0, 8, "sleep cycles");
    count_lp(1, 4, "settle cycles");
    chk("calibrate", 8'h01, calib);
    wait_lp(0, 1'b1);
    wr(CLT_ADDR_LP_CTRL, 8'h88);
    rd(CLT_ADDR_IRQ_STATUS, 8'h18);
    ticks(2);
    chk("masked irq", 8'h00, irq);
    wr(CLT_ADDR_IRQ_MASK, 8'h18);
    ticks(2);
    chk("irq", 8'h01, irq);
    wr(CLT_ADDR_IRQ_STATUS, 8'h18);
    ticks(2);
    chk("cleared irq", 8'h00, irq);
    $display("test timed sleep done");
    wr(CLT_ADDR_LP_CTRL, 8'h8b);
    wait_lp(0, 1'b1);
    ticks(20);
    chk("trigger sleep", 8'h01, sleep);
    rd(CLT_ADDR_LP_STATE, {4'h0, want, 3'h5});
    wr(CLT_ADDR_SOFT_TRIG, 8'h00);
    wait_lp(1, 1'b1);
    wr(CLT_ADDR_LP_CTRL, 8'h88);
    wr(CLT_ADDR_SOFT_TRIG, 8'h01);
    $display("test trigger sleep done");
    conclude();
  end
endmodule

// File: tb/clt_far_side.sv
`timescale 1ns/1ps
module clt_far_side (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic calibrate,
  output logic      pin,
  output logic      cal_done
);
  logic [1:0] age;
  initial begin
    pin = 1'b0;
    cal_done = 1'b0;
    age = 2'h0;
  end
  // The pin is launched from a flop of its own, so it moves one edge after the bench asks for it.
  always @(posedge clk) begin
    pin <= want;
    age <= calibrate ? age + 2'h1 : 2'h0;
    cal_done <= calibrate && age == 2'h2;
  end
endmodule
